// >>> rtl/cell_cfg_pkg.sv
/*
  shared constants, the mode enumeration and the state carrier of the
  configurable logic cell configuration block.
  assumes a 32-bit apb slave; register byte address is four times its index.
*/
package cell_cfg_pkg;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'h1e10;
  localparam logic [15:0] IDX_INVERT = 16'h1e11;
  localparam logic [15:0] IDX_SEL1 = 16'h1e12;
  localparam logic [15:0] IDX_SEL2 = 16'h1e13;
  localparam logic [15:0] IDX_STATUS = 16'h1e40;
  localparam logic [15:0] IDX_MASK = 16'h1e41;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_RISE_BIT = 4;
  localparam int CTRL_FALL_BIT = 3;
  localparam int MODE_W = 3;
  // inversion register fields
  localparam int OUT_INVERT_BIT = 7;
  localparam int GATE_W = 4;
  // source select field and status field
  localparam int SEL_W = 6;
  localparam int FLAG_BIT = 0;
  localparam int DATA_W = 32;

  // source map
  localparam int NUM_SRC = 64;
  localparam int NUM_PINS = 4;
  localparam int NUM_CLKS = 7;
  localparam int NUM_PERIPH_LO = 21;
  localparam int NUM_CELLS = 4;
  localparam int NUM_PERIPH_HI = 4;
  localparam int NUM_WAVE = 4;
  localparam logic [5:0] SRC_PIN0 = 6'h00;
  localparam logic [5:0] SRC_CLK0 = 6'h04;
  localparam logic [5:0] SRC_PERIPH_LO0 = 6'h0b;
  localparam logic [5:0] SRC_CELL0 = 6'h20;
  localparam logic [5:0] SRC_PERIPH_HI0 = 6'h24;
  localparam logic [5:0] SRC_RES_A0 = 6'h28;
  localparam logic [5:0] SRC_RES_A1 = 6'h29;
  localparam logic [5:0] SRC_WAVE0 = 6'h2a;
  localparam logic [5:0] SRC_RES_B0 = 6'h2e;

  // reset values
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [3:0] GATE_INV_RESET = 4'h0;

  typedef enum logic [MODE_W-1:0] {
    MODE_AND_OR,
    MODE_OR_XOR,
    MODE_AND4,
    MODE_SR_LATCH,
    MODE_D_SET_RESET,
    MODE_D2_RESET,
    MODE_JK_RESET,
    MODE_LATCH_SET_RESET
  } mode_e;

  typedef struct packed {
    logic enable;
    logic rise_en;
    logic fall_en;
    mode_e mode;
    logic out_inv;
    logic [GATE_W-1:0] gate_inv;
    logic [SEL_W-1:0] sel1;
    logic [SEL_W-1:0] sel2;
    logic cell_q;
    logic g1_prev;
    logic out;
    logic flag;
    logic mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } cell_state_s;

  function automatic logic [15:0] byte_addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction : byte_addr

endpackage : cell_cfg_pkg

// >>> rtl/sync2.sv
/*
  two flip-flop synchroniser for a vector of independent levels.
  assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st.meta = i_async;
    next_st.stable = st.meta;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable;
endmodule : sync2
`default_nettype wire

// >>> rtl/source_mux.sv
/*
  selects one of the 64 cell data sources by a 6-bit code.
  assumes the source vector is already in the i_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module source_mux (
  // selection
  input wire logic [cell_cfg_pkg::SEL_W-1:0] i_sel,
  input wire logic [cell_cfg_pkg::NUM_SRC-1:0] i_sources,
  // selected level
  output logic o_data
);
  function automatic logic is_reserved(input logic [5:0] code);
    return (code == cell_cfg_pkg::SRC_RES_A0) ||
           (code == cell_cfg_pkg::SRC_RES_A1) ||
           (code >= cell_cfg_pkg::SRC_RES_B0);
  endfunction : is_reserved

  always_comb begin
    if (is_reserved(i_sel)) begin
      o_data = 1'b0;
    end else begin
      o_data = i_sources[i_sel];
    end
  end
endmodule : source_mux
`default_nettype wire

// >>> rtl/logic_cell_cfg.sv
/*
  one configurable logic cell: apb register file, two data source
  selectors, gate inversion, eight cell functions, output inversion,
  edge interrupt with sticky status and mask.
  assumes gates 3 and 4 come from gate steering logic on i_clk, other
  on-chip sources are on i_clk, pins and clock sources are asynchronous.
*/
// How it works
// - mode codes 000 to 011: and-or, or-xor, four-input and, set-reset latch.
// - mode 111: one-input transparent latch with set and reset.
// - mode 110: j-k flip-flop with reset.
// - mode 101: d flip-flop on a two-input data function, with reset.
// - mode 100: one-input d flip-flop with set and reset.
// - output invert bit 7 flips the cell output, clear passes it.
// - gate invert bits 0 to 3 flip each gate before the function.
// - a 6-bit field in bits 5:0 picks the source of data input 1.
// - a second 6-bit field picks data input 2, same encoding.
// - codes: 0-3 pins, 4-10 clocks, 32-35 cells, 42-45 waveforms.
// - select fields reset to code 0 on i_reset, kept across other resets.
// - cell disabled holds the output at zero; enabled runs the function.
// - interrupt flag sets on rising or falling output edge as enabled.
// - a read-only bit shows the cell output after inversion.
`timescale 1ns/1ns
`default_nettype none
module logic_cell_cfg #(
  parameter int CELL_INDEX = 0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // asynchronous sources
  input wire logic [cell_cfg_pkg::NUM_PINS-1:0] i_pin_in,
  input wire logic [cell_cfg_pkg::NUM_CLKS-1:0] i_clk_src,
  // on-chip sources in the i_clk domain
  input wire logic [cell_cfg_pkg::NUM_PERIPH_LO-1:0] i_periph_lo,
  input wire logic [cell_cfg_pkg::NUM_CELLS-1:0] i_peer_cells,
  input wire logic [cell_cfg_pkg::NUM_PERIPH_HI-1:0] i_periph_hi,
  input wire logic [cell_cfg_pkg::NUM_WAVE-1:0] i_waveform,
  // gates 3 and 4 from the gate steering logic
  input wire logic i_gate3,
  input wire logic i_gate4,
  // cell results
  output logic o_cell_output,
  output logic o_irq,
  // selected data inputs, for the gate steering logic
  output logic o_data1,
  output logic o_data2
);
  localparam int ASYNC_W = cell_cfg_pkg::NUM_PINS + cell_cfg_pkg::NUM_CLKS;

  cell_cfg_pkg::cell_state_s st;
  cell_cfg_pkg::cell_state_s next_st;

  logic [ASYNC_W-1:0] async_sync;
  logic [cell_cfg_pkg::NUM_SRC-1:0] sources;
  logic [cell_cfg_pkg::NUM_CELLS-1:0] cells;
  logic data1;
  logic data2;
  logic [cell_cfg_pkg::GATE_W-1:0] gates;
  logic [cell_cfg_pkg::GATE_W-1:0] gates_raw;
  logic hit_control;
  logic hit_invert;
  logic hit_sel1;
  logic hit_sel2;
  logic hit_status;
  logic hit_mask;
  logic hit_any;
  logic setup;
  logic wr;
  logic [31:0] rdata;
  logic g1_rise;
  logic q_next;
  logic edge_event;
  logic out_next;

  // pins and clock sources cross into i_clk before any decode
  sync2 #(
    .WIDTH(ASYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_clk_src, i_pin_in}),
    .o_sync(async_sync)
  );

  // the own slot carries this cell's output, peers supply the rest
  always_comb begin
    cells = i_peer_cells;
    cells[CELL_INDEX] = st.out;
  end

  always_comb begin
    sources = '0;
    sources[cell_cfg_pkg::SRC_PIN0 +: ASYNC_W] = async_sync;
    sources[cell_cfg_pkg::SRC_PERIPH_LO0 +: cell_cfg_pkg::NUM_PERIPH_LO] =
      i_periph_lo;
    sources[cell_cfg_pkg::SRC_CELL0 +: cell_cfg_pkg::NUM_CELLS] = cells;
    sources[cell_cfg_pkg::SRC_PERIPH_HI0 +: cell_cfg_pkg::NUM_PERIPH_HI] =
      i_periph_hi;
    sources[cell_cfg_pkg::SRC_WAVE0 +: cell_cfg_pkg::NUM_WAVE] = i_waveform;
  end

  source_mux u_mux1 (
    .i_sel(st.sel1),
    .i_sources(sources),
    .o_data(data1)
  );

  source_mux u_mux2 (
    .i_sel(st.sel2),
    .i_sources(sources),
    .o_data(data2)
  );

  assign gates_raw = {i_gate4, i_gate3, data2, data1};
  assign gates = gates_raw ^ st.gate_inv;

  // address decode; the address is held through setup and access
  always_comb begin
    hit_control =
      i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_CONTROL);
    hit_invert = i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_INVERT);
    hit_sel1 = i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_SEL1);
    hit_sel2 = i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_SEL2);
    hit_status = i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_STATUS);
    hit_mask = i_paddr == cell_cfg_pkg::byte_addr(cell_cfg_pkg::IDX_MASK);
    hit_any = hit_control | hit_invert | hit_sel1 | hit_sel2 | hit_status |
              hit_mask;
  end

  assign setup = i_psel & ~i_penable;
  assign wr = i_psel & i_penable & st.pready & i_pwrite & ~st.pslverr;

  always_comb begin
    rdata = '0;
    if (hit_control) begin
      rdata[cell_cfg_pkg::CTRL_ENABLE_BIT] = st.enable;
      rdata[cell_cfg_pkg::CTRL_OUT_BIT] = st.out;
      rdata[cell_cfg_pkg::CTRL_RISE_BIT] = st.rise_en;
      rdata[cell_cfg_pkg::CTRL_FALL_BIT] = st.fall_en;
      rdata[cell_cfg_pkg::MODE_W-1:0] = st.mode;
    end
    if (hit_invert) begin
      rdata[cell_cfg_pkg::OUT_INVERT_BIT] = st.out_inv;
      rdata[cell_cfg_pkg::GATE_W-1:0] = st.gate_inv;
    end
    if (hit_sel1) begin
      rdata[cell_cfg_pkg::SEL_W-1:0] = st.sel1;
    end
    if (hit_sel2) begin
      rdata[cell_cfg_pkg::SEL_W-1:0] = st.sel2;
    end
    if (hit_status) begin
      rdata[cell_cfg_pkg::FLAG_BIT] = st.flag;
    end
    if (hit_mask) begin
      rdata[cell_cfg_pkg::FLAG_BIT] = st.mask;
    end
  end

  assign g1_rise = gates[0] & ~st.g1_prev;

  // cell function; sequential modes act on i_clk, so a gate clock is
  // seen one cycle late and must be slower than half of i_clk
  always_comb begin
    q_next = st.cell_q;
    case (st.mode)
      cell_cfg_pkg::MODE_AND_OR: begin
        q_next = (gates[0] & gates[1]) | (gates[2] & gates[3]);
      end
      cell_cfg_pkg::MODE_OR_XOR: begin
        q_next = (gates[0] | gates[1]) ^ (gates[2] | gates[3]);
      end
      cell_cfg_pkg::MODE_AND4: begin
        q_next = &gates;
      end
      cell_cfg_pkg::MODE_SR_LATCH: begin
        if (gates[0] | gates[1]) begin
          q_next = 1'b1;
        end else if (gates[2] | gates[3]) begin
          q_next = 1'b0;
        end
      end
      cell_cfg_pkg::MODE_D_SET_RESET: begin
        if (gates[2]) begin
          q_next = 1'b0;
        end else if (gates[3]) begin
          q_next = 1'b1;
        end else if (g1_rise) begin
          q_next = gates[1];
        end
      end
      cell_cfg_pkg::MODE_D2_RESET: begin
        if (gates[2]) begin
          q_next = 1'b0;
        end else if (g1_rise) begin
          q_next = gates[1] ^ gates[3];
        end
      end
      cell_cfg_pkg::MODE_JK_RESET: begin
        if (gates[2]) begin
          q_next = 1'b0;
        end else if (g1_rise) begin
          case ({gates[1], gates[3]})
            2'b11: q_next = ~st.cell_q;
            2'b10: q_next = 1'b1;
            2'b01: q_next = 1'b0;
            default: q_next = st.cell_q;
          endcase
        end
      end
      cell_cfg_pkg::MODE_LATCH_SET_RESET: begin
        if (gates[2]) begin
          q_next = 1'b0;
        end else if (gates[3]) begin
          q_next = 1'b1;
        end else if (gates[0]) begin
          q_next = gates[1];
        end
      end
      default: begin
        q_next = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.g1_prev = gates[0];
    next_st.cell_q = st.enable ? q_next : 1'b0;
    next_st.out = out_next;
    // apb: data is latched in setup, so pready comes from a flop
    next_st.pready = setup;
    if (setup) begin
      next_st.prdata = rdata;
      next_st.pslverr = ~hit_any;
    end
    if (wr && hit_control) begin
      next_st.enable = i_pwdata[cell_cfg_pkg::CTRL_ENABLE_BIT];
      next_st.rise_en = i_pwdata[cell_cfg_pkg::CTRL_RISE_BIT];
      next_st.fall_en = i_pwdata[cell_cfg_pkg::CTRL_FALL_BIT];
      next_st.mode = cell_cfg_pkg::mode_e'(i_pwdata[cell_cfg_pkg::MODE_W-1:0]);
    end
    if (wr && hit_invert) begin
      next_st.out_inv = i_pwdata[cell_cfg_pkg::OUT_INVERT_BIT];
      next_st.gate_inv = i_pwdata[cell_cfg_pkg::GATE_W-1:0];
    end
    if (wr && hit_sel1) begin
      next_st.sel1 = i_pwdata[cell_cfg_pkg::SEL_W-1:0];
    end
    if (wr && hit_sel2) begin
      next_st.sel2 = i_pwdata[cell_cfg_pkg::SEL_W-1:0];
    end
    if (wr && hit_mask) begin
      next_st.mask = i_pwdata[cell_cfg_pkg::FLAG_BIT];
    end
    // write one to clear; an edge in the same cycle wins
    if (wr && hit_status && i_pwdata[cell_cfg_pkg::FLAG_BIT]) begin
      next_st.flag = 1'b0;
    end
    if (edge_event) begin
      next_st.flag = 1'b1;
    end
    next_st.irq = next_st.flag & next_st.mask;
  end

  // taken from q_next, not next_st, so no path loops through the state
  assign out_next = st.enable ? (q_next ^ st.out_inv) : 1'b0;
  assign edge_event = (st.rise_en & out_next & ~st.out) |
                      (st.fall_en & ~out_next & st.out);

  // select fields take a fixed value here; only a power-on or
  // brown-out reset may drive i_reset, other resets leave them alone
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.sel1 <= cell_cfg_pkg::SEL_RESET;
      st.sel2 <= cell_cfg_pkg::SEL_RESET;
      st.gate_inv <= cell_cfg_pkg::GATE_INV_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready = st.pready;
  assign o_prdata = st.prdata;
  assign o_pslverr = st.pslverr;
  assign o_cell_output = st.out;
  assign o_irq = st.irq;
  assign o_data1 = data1;
  assign o_data2 = data2;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  disabled_output_zero_a: assert property (
    !st.enable |=> !st.out)
    else $error("disabled cell output not zero");
  and4_all_high_a: assert property (
    st.enable && st.mode == cell_cfg_pkg::MODE_AND4 && (&gates) &&
    !st.out_inv |=> st.out)
    else $error("four-input and did not give one");
  output_invert_a: assert property (
    st.enable && st.mode == cell_cfg_pkg::MODE_AND4 && (&gates) &&
    st.out_inv |=> !st.out)
    else $error("output inversion not applied");
  gate_invert_a: assert property (
    st.enable && st.mode == cell_cfg_pkg::MODE_AND_OR &&
    st.gate_inv == 4'hf && gates_raw == 4'h0 && !st.out_inv |=> st.out)
    else $error("gate inversion not applied");
  jk_toggle_a: assert property (
    st.enable && st.mode == cell_cfg_pkg::MODE_JK_RESET && !gates[2] &&
    g1_rise && gates[1] && gates[3] |=> st.cell_q != $past(st.cell_q))
    else $error("j-k flip-flop did not toggle");
  dff_reset_a: assert property (
    st.enable && st.mode == cell_cfg_pkg::MODE_D_SET_RESET && gates[2]
    |=> !st.cell_q)
    else $error("d flip-flop reset not honoured");
  reserved_zero_a: assert property (
    st.sel1 == cell_cfg_pkg::SRC_RES_A0 || st.sel1 >= cell_cfg_pkg::SRC_RES_B0
    |-> !data1)
    else $error("reserved source not zero");
  wave_select_a: assert property (
    st.sel2 == cell_cfg_pkg::SRC_WAVE0 |-> data2 == i_waveform[0])
    else $error("waveform source not routed");
  rise_flag_a: assert property (
    st.rise_en && !st.out ##1 st.out |-> st.flag)
    else $error("rising edge did not set flag");
  out_bit_read_a: assert property (
    setup && hit_control |=> o_prdata[cell_cfg_pkg::CTRL_OUT_BIT] ==
    $past(st.out))
    else $error("output bit read wrong");
  sel_write_a: assert property (
    wr && hit_sel1 |=> st.sel1 == $past(i_pwdata[cell_cfg_pkg::SEL_W-1:0]))
    else $error("data 1 select not written");

  irq_seen_c: cover property (st.flag && st.mask ##1 o_irq);
  jk_mode_c: cover property (st.enable &&
    st.mode == cell_cfg_pkg::MODE_JK_RESET && g1_rise);
  latch_mode_c: cover property (st.enable &&
    st.mode == cell_cfg_pkg::MODE_LATCH_SET_RESET && gates[0]);
  unmapped_c: cover property (o_pready && o_pslverr);
endmodule : logic_cell_cfg
`default_nettype wire

// >>> tb/far_sources.sv
/*
  far side model: pins, clock sources, on-chip peripherals, peer cells and
  waveform outputs, all taken from one vector where bit n is source code n.
  assumes the bench changes the vector just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module far_sources (
  // source vector
  input wire logic [63:0] i_src,
  // to the cell
  output logic [3:0] o_pin_in,
  output logic [6:0] o_clk_src,
  output logic [20:0] o_periph_lo,
  output logic [3:0] o_peer_cells,
  output logic [3:0] o_periph_hi,
  output logic [3:0] o_waveform
);
  // codes 40, 41 and 46 to 63 have no wire; bits there must not leak in
  assign o_pin_in = i_src[3:0];
  assign o_clk_src = i_src[10:4];
  assign o_periph_lo = i_src[31:11];
  assign o_peer_cells = i_src[35:32];
  assign o_periph_hi = i_src[39:36];
  assign o_waveform = i_src[45:42];
endmodule : far_sources
`default_nettype wire

// >>> tb/tb.sv
/*
  self-checking bench of logic_cell_cfg: apb registers, source selection,
  the eight cell functions, inversion and the edge interrupt.
  assumes one setup and one access cycle per apb transfer.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [15:0] CTL = cell_cfg_pkg::IDX_CONTROL;
  localparam logic [15:0] INV = cell_cfg_pkg::IDX_INVERT;
  localparam logic [15:0] SL1 = cell_cfg_pkg::IDX_SEL1;
  localparam logic [15:0] SL2 = cell_cfg_pkg::IDX_SEL2;
  localparam logic [15:0] STA = cell_cfg_pkg::IDX_STATUS;
  localparam logic [15:0] MSK = cell_cfg_pkg::IDX_MASK;
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, err;
  logic g3, g4, cell_out, irq, d1, d2;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] src;
  logic [3:0] pin, cells, hi, wave;
  logic [6:0] ck;
  logic [20:0] lo;
  int n_mismatch, comparisons;
  logic [15:0] regs [0:5] = '{CTL, INV, SL1, SL2, STA, MSK};
  // first twelve codes are wired, the last four reserved
  logic [5:0] codes [0:15] = '{6'h00, 6'h03, 6'h04, 6'h0a, 6'h0b, 6'h1f,
    6'h21, 6'h23, 6'h24, 6'h27, 6'h2a, 6'h2d, 6'h28, 6'h29, 6'h2e, 6'h3f};
  // {mode, gate4..gate1, expected output}
  logic [7:0] seq [0:27] = '{8'h63, 8'h61, 8'h68, 8'h60, 8'h6b, 8'h84,
    8'h87, 8'h81, 8'h88, 8'h91, 8'h98, 8'hb0, 8'hb3, 8'hb5, 8'hb6, 8'hc4,
    8'hc7, 8'hd1, 8'hd2, 8'hd4, 8'hd7, 8'hd5, 8'hd6, 8'he7, 8'he2, 8'he4,
    8'hf1, 8'he8};

  far_sources far_sources_inst (.i_src(src), .o_pin_in(pin),
    .o_clk_src(ck), .o_periph_lo(lo), .o_peer_cells(cells),
    .o_periph_hi(hi), .o_waveform(wave));
  logic_cell_cfg #(.CELL_INDEX(0)) logic_cell_cfg_inst (.i_clk(i_clk),
    .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_pin_in(pin), .i_clk_src(ck), .i_periph_lo(lo), .i_peer_cells(cells),
    .i_periph_hi(hi), .i_waveform(wave), .i_gate3(g3), .i_gate4(g4),
    .o_cell_output(cell_out), .o_irq(irq), .o_data1(d1), .o_data2(d2));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // entered just after an edge; leaves one idle edge behind the transfer
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic rd_is(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check("register read", rd, exp);
  endtask : rd_is

  // gate 1 and 2 come through data1 (code 11) and data2 (code 12)
  task automatic set_gates(input logic [3:0] g);
    src <= {51'h0, g[1], g[0], 11'h0};
    g3 <= g[2];
    g4 <= g[3];
    repeat (3) @(posedge i_clk);
  endtask : set_gates

  function automatic logic comb(input int m, input logic [3:0] g);
    case (m)
      0: return (g[0] & g[1]) | (g[2] & g[3]);
      1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction : comb

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    logic [2:0] mode;
    i_reset = 1'b1;
    {psel, penable, pwrite, g3, g4} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    src = 64'h0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    foreach (regs[i]) rd_is(regs[i], 32'h0);
    apb(1'b0, 16'h1e14, 32'h0);
    check("unmapped read", {31'h0, err}, 32'h1);
    apb(1'b1, 16'h1e14, 32'h0);
    check("unmapped write", {31'h0, err}, 32'h1);
    apb(1'b1, INV, 32'hff);
    rd_is(INV, 32'h8f);
    apb(1'b1, SL1, 32'hff);
    rd_is(SL1, 32'h3f);
    apb(1'b1, SL2, 32'hff);
    rd_is(SL2, 32'h3f);
    apb(1'b1, CTL, 32'h1f);
    rd_is(CTL, 32'h1f);
    $display("test registers done");
    foreach (codes[i]) begin
      apb(1'b1, SL1, {26'h0, codes[i]});
      apb(1'b1, SL2, {26'h0, codes[i]});
      src <= 64'h1 << codes[i];
      repeat (4) @(posedge i_clk);
      check("data1 lone source", {31'h0, d1}, 32'(i < 12));
      check("data2 lone source", {31'h0, d2}, 32'(i < 12));
      src <= ~(64'h1 << codes[i]);
      repeat (4) @(posedge i_clk);
      check("data1 other sources", {31'h0, d1}, 32'h0);
      check("data2 other sources", {31'h0, d2}, 32'h0);
    end
    $display("test sources done");
    apb(1'b1, SL1, 32'h0b);
    apb(1'b1, SL2, 32'h0c);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, INV, (m == 1) ? 32'h8a : 32'h0a);
      apb(1'b1, CTL, 32'h80 | m);
      for (int g = 0; g < 16; g++) begin
        set_gates(4'(g));
        check("combinational output", {31'h0, cell_out},
          32'(comb(m, 4'(g) ^ 4'ha) ^ (m == 1)));
      end
    end
    apb(1'b1, INV, 32'h0f);
    apb(1'b1, CTL, 32'h80);
    set_gates(4'h0);
    check("all gates inverted", {31'h0, cell_out}, 32'h1);
    apb(1'b1, INV, 32'h8f);
    apb(1'b1, CTL, 32'h82);
    repeat (2) @(posedge i_clk);
    check("inverted and4", {31'h0, cell_out}, 32'h0);
    apb(1'b1, INV, 32'h0);
    $display("test combinational done");
    mode = 3'h0;
    foreach (seq[i]) begin
      if (seq[i][7:5] != mode) begin
        mode = seq[i][7:5];
        apb(1'b1, CTL, {29'h0, mode});
        repeat (2) @(posedge i_clk);
        check("disabled output", {31'h0, cell_out}, 32'h0);
        apb(1'b1, CTL, {24'h0, 5'h10, mode});
      end
      set_gates(seq[i][4:1]);
      check("sequential output", {31'h0, cell_out},
        {31'h0, seq[i][0]});
      apb(1'b0, CTL, 32'h0);
      check("output status bit", {31'h0, rd[5]}, {31'h0, seq[i][0]});
    end
    $display("test sequential done");
    apb(1'b1, STA, 32'h1);
    set_gates(4'h0);
    apb(1'b1, CTL, 32'h92);
    apb(1'b1, MSK, 32'h1);
    set_gates(4'hf);
    check("irq on rise", {31'h0, irq}, 32'h1);
    rd_is(STA, 32'h1);
    apb(1'b1, STA, 32'h1);
    rd_is(STA, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    set_gates(4'h0);
    rd_is(STA, 32'h0);
    apb(1'b1, CTL, 32'h8a);
    set_gates(4'hf);
    rd_is(STA, 32'h0);
    set_gates(4'h0);
    rd_is(STA, 32'h1);
    check("irq on fall", {31'h0, irq}, 32'h1);
    apb(1'b1, MSK, 32'h0);
    repeat (2) @(posedge i_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
